// ### core/pir_defs.vh
// constants for the peripheral interrupt flag and enable block
// Function
// - enable bit 7 gates the data EEPROM write done interrupt
// - enable bit 6 gates the conversion done interrupt, converter variant only
// - enable bit 3 gates the comparator change interrupt
// - enable bit 0 gates the timer one overflow interrupt
// - bits 5-4 and 2-1 of both registers read zero, ignore writes
// - flags set on their event regardless of any enable
// - flag bit 7 sets on EEPROM write done, holds until cleared
// - flag bit 6 sets on conversion done, holds until written zero
// - flag bit 3 sets on comparator change, holds until written zero
// - flag bit 0 sets on timer one overflow, holds until written zero
// - no peripheral request unless peripheral gate is set
// - global gate clear blocks all peripheral requests but not IRQ, set allows unmasked ones while peripheral gate is set
`ifndef PIR_DEFS_VH
`define PIR_DEFS_VH
`define PIR_OFS_FLAGS     12'h00C
`define PIR_OFS_ENABLES   12'h08C
`define PIR_OFS_CONTROL   12'h100
`define PIR_OFS_IRQ_STAT  12'h104
`define PIR_OFS_IRQ_MASK  12'h108
`define PIR_BIT_EEPROM    7
`define PIR_BIT_CONV      6
`define PIR_BIT_COMP      3
`define PIR_BIT_TIMER_ONE      0
`define PIR_IMPL_MASK     8'hC9
`define PIR_BIT_PGATE     0
`define PIR_BIT_GGATE     1
`define PIR_RST_FLAGS     8'h00
`define PIR_RST_ENABLES   8'h00
`define PIR_RST_CONTROL   2'h0
`define PIR_RST_IRQ       4'h0
`endif

// ### core/pir_flag_bit.v
// one sticky event flag with software write
`timescale 1ns/1ps
module pir_flag_bit
(
  // clock and reset
  input  wire clk,
  input  wire resetn,
  // event and software write
  input  wire set_evt,
  input  wire wr_en,
  input  wire wr_val,
  // flag state
  output reg  flag_r
);
  // set wins over a software clear
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      flag_r <= 1'b0;
    else if (set_evt)
      flag_r <= 1'b1;
    else if (wr_en)
      flag_r <= wr_val;
  end
endmodule // pir_flag_bit

// ### core/pir_regs.v
// peripheral interrupt flag and enable registers with apb slave
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "pir_defs.vh"
module pir_regs
#(
  parameter HAS_CONVERTER = 1
)
(
  // clock and reset
  input  wire        CLK,
  input  wire        RESETN,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  // peripheral event pulses, same clock
  input  wire        EEPROM_WRITE_DONE,
  input  wire        CONVERSION_DONE,
  input  wire        COMPARATOR_CHANGE,
  input  wire        TIMER1_OVERFLOW,
  // requests
  output wire        PERIPH_IRQ_REQ,
  output wire        IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire        wr = PSEL & PENABLE & PWRITE;
  wire        rd = PSEL & PENABLE & ~PWRITE;
  wire        sel_flags = (PADDR == `PIR_OFS_FLAGS);
  wire        sel_en    = (PADDR == `PIR_OFS_ENABLES);
  wire        sel_ctl   = (PADDR == `PIR_OFS_CONTROL);
  wire        sel_st    = (PADDR == `PIR_OFS_IRQ_STAT);
  wire        sel_mask  = (PADDR == `PIR_OFS_IRQ_MASK);
  wire        mapped = sel_flags | sel_en | sel_ctl | sel_st | sel_mask;

  // register map, byte addresses
  //   flags    sticky event flags
  //   enables  per-source enables
  //   control  bit 0 peripheral gate, bit 1 global gate
  //   status   event status, cleared by read
  //   mask     event status mask
  // setup phase of a read, when read data is captured
  wire        rd_setup  = PSEL & ~PENABLE & ~PWRITE;
  // write strobes, one per writable register
  wire        wr_flags  = wr & sel_flags;
  wire        wr_en_reg = wr & sel_en;
  wire        wr_ctl    = wr & sel_ctl;
  wire        wr_mask   = wr & sel_mask;

  // zero wait states, unmapped address answers with error
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  ////////////////////////////////////////////////////////////////////////
  // flag bits
  wire [7:0] flags;
  wire [3:0] evt;
  wire       conv_evt = CONVERSION_DONE & (HAS_CONVERTER != 0);
  wire       flag_wr = wr_flags;

  assign evt = {EEPROM_WRITE_DONE, conv_evt, COMPARATOR_CHANGE,
                TIMER1_OVERFLOW};

  // events placed at their flag positions
  wire [7:0] evt_bits = {evt[3], evt[2], 2'h0, evt[1], 2'h0, evt[0]};

  // flags set on events regardless of enables
  pir_flag_bit u_flag_ee
  (
    .clk     (CLK),
    .resetn  (RESETN),
    .set_evt (evt[3]),
    .wr_en   (flag_wr),
    .wr_val  (PWDATA[`PIR_BIT_EEPROM]),
    .flag_r  (flags[7])
  );

  pir_flag_bit u_flag_conv
  (
    .clk     (CLK),
    .resetn  (RESETN),
    .set_evt (evt[2]),
    .wr_en   (flag_wr & (HAS_CONVERTER != 0)),
    .wr_val  (PWDATA[`PIR_BIT_CONV]),
    .flag_r  (flags[6])
  );

  pir_flag_bit u_flag_comp
  (
    .clk     (CLK),
    .resetn  (RESETN),
    .set_evt (evt[1]),
    .wr_en   (flag_wr),
    .wr_val  (PWDATA[`PIR_BIT_COMP]),
    .flag_r  (flags[3])
  );

  pir_flag_bit u_flag_tmr
  (
    .clk     (CLK),
    .resetn  (RESETN),
    .set_evt (evt[0]),
    .wr_en   (flag_wr),
    .wr_val  (PWDATA[`PIR_BIT_TIMER_ONE]),
    .flag_r  (flags[0])
  );

  // unimplemented positions tie to zero
  assign flags[5:4] = 2'h0;
  assign flags[2:1] = 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // enables and gates
  reg  [7:0] enables_r;
  reg  [1:0] control_r;
  wire [7:0] en_mask = HAS_CONVERTER ? `PIR_IMPL_MASK : 8'h89;

  // enable register, unimplemented bits masked off
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      enables_r <= `PIR_RST_ENABLES;
    else if (wr_en_reg)
      enables_r <= PWDATA[7:0] & en_mask;
  end

  // gate register
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      control_r <= `PIR_RST_CONTROL;
    else if (wr_ctl)
      control_r <= PWDATA[1:0];
  end

  // per-source pending, each under its own enable
  wire pend_ee   = flags[`PIR_BIT_EEPROM]
                 & enables_r[`PIR_BIT_EEPROM];
  wire pend_conv = flags[`PIR_BIT_CONV]
                 & enables_r[`PIR_BIT_CONV];
  wire pend_comp = flags[`PIR_BIT_COMP]
                 & enables_r[`PIR_BIT_COMP];
  wire pend_tmr  = flags[`PIR_BIT_TIMER_ONE]
                 & enables_r[`PIR_BIT_TIMER_ONE];
  wire pending   = pend_ee | pend_conv | pend_comp | pend_tmr;

  // both gates must be open for a request
  wire periph_gate = control_r[`PIR_BIT_PGATE];
  wire global_gate = control_r[`PIR_BIT_GGATE];
  assign PERIPH_IRQ_REQ = pending & periph_gate & global_gate;

  ////////////////////////////////////////////////////////////////////////
  // sticky event status, cleared by read, masked onto IRQ
  reg  [3:0] irq_stat_r;
  reg  [3:0] irq_mask_r;
  wire       st_rd = rd & sel_st;

  // only the bits handed out by the read are cleared
  wire [3:0] stat_clr = st_rd ? PRDATA[3:0] : 4'h0;

  // sticky status, new event wins over a clearing read
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      irq_stat_r <= `PIR_RST_IRQ;
    else
      irq_stat_r <= (irq_stat_r & ~stat_clr) | evt;
  end

  // status mask
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      irq_mask_r <= `PIR_RST_IRQ;
    else if (wr_mask)
      irq_mask_r <= PWDATA[3:0];
  end

  assign IRQ = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////
  // read data register, loaded in setup phase
  reg [31:0] rdata_nxt;

  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    case (1'b1)
      sel_flags: rdata_nxt = {24'h000000, flags | evt_bits};
      sel_en:    rdata_nxt = {24'h000000, enables_r};
      sel_ctl:   rdata_nxt = {30'h00000000, control_r};
      sel_st:    rdata_nxt = {28'h0000000, irq_stat_r | evt};
      sel_mask:  rdata_nxt = {28'h0000000, irq_mask_r};
      default:   rdata_nxt = 32'h0000_0000;
    endcase
  end

  // read data flop: loaded in setup, held through access, else zero
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      PRDATA <= 32'h0000_0000;
    else if (rd_setup)
      PRDATA <= rdata_nxt;
    else if (!rd)
      PRDATA <= 32'h0000_0000;
  end

endmodule // pir_regs

// ### verification/pir_props.sv
// port assertions for the peripheral interrupt registers
`timescale 1ns/1ps
`include "pir_defs.vh"
module pir_props
(
  // clock, reset and apb
  input wire        CLK,
  input wire        RESETN,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PRDATA,
  // events and request
  input wire        EEPROM_WRITE_DONE,
  input wire        CONVERSION_DONE,
  input wire        COMPARATOR_CHANGE,
  input wire        TIMER1_OVERFLOW,
  input wire        PERIPH_IRQ_REQ
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // access-phase reads of flags and control
  wire rd = PSEL & PENABLE & !PWRITE;
  wire rf = rd & (PADDR == `PIR_OFS_FLAGS);
  wire rc = rd & (PADDR == `PIR_OFS_CONTROL);
  a_rsvd_zero: assert property (rf |-> !(|(PRDATA & 32'hFFFFFF36)))
    else $error("reserved flag bits set");
  a_eeprom_set: assert property (EEPROM_WRITE_DONE ##1 rf |-> PRDATA[7])
    else $error("eeprom flag missing");
  a_conv_set: assert property (CONVERSION_DONE ##1 rf |-> PRDATA[6])
    else $error("conversion flag missing");
  a_comp_set: assert property (COMPARATOR_CHANGE ##1 rf |-> PRDATA[3])
    else $error("comparator flag missing");
  a_tmr_set: assert property (TIMER1_OVERFLOW ##1 rf |-> PRDATA[0])
    else $error("timer flag missing");
  a_pgate_off: assert property (rc && !PRDATA[0] |-> !PERIPH_IRQ_REQ)
    else $error("request without peripheral gate");
  a_ggate_off: assert property (rc && !PRDATA[1] |-> !PERIPH_IRQ_REQ)
    else $error("request without global gate");
  a_no_flag: assert property (rf && PRDATA == 0 |-> !PERIPH_IRQ_REQ)
    else $error("request without flag");
  cover property (PERIPH_IRQ_REQ);
  cover property (rf && PRDATA[7]);
  cover property (rc && PRDATA[1:0] == 2'h3);
endmodule // pir_props
////////////////////////////////////////////////////////////////////////////
bind pir_regs pir_props u_props (.*);

// ### verification/pir_periph.sv
// peripheral event source model
`timescale 1ns/1ps
module pir_periph
(
  // clock and trigger
  input  wire       clk,
  input  wire [3:0] fire,
  // event pulses, one high cycle per fire cycle
  output reg  [3:0] evt
);
  initial evt = 4'h0;
  always @(posedge clk)
    evt <= fire;
endmodule // pir_periph

// ### verification/pir_regs_test.sv
// self-checking bench for the peripheral interrupt registers
`timescale 1ns/1ps
`include "pir_defs.vh"
module peripheral_interrupt_regs_test;
  reg         clk = 1'h0, rstn = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  reg  [11:0] pa = 12'h0;
  reg  [31:0] pwd = 32'h0, d, v;
  reg  [3:0]  fire = 4'h0;
  reg         e;
  wire [31:0] prd;
  wire [3:0]  evt;
  wire        rdy, err, req, irq;
  integer     n_fail = 0, total_checks = 0, i;
  pir_regs u_dut (.CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy),
    .PSLVERR(err), .EEPROM_WRITE_DONE(evt[3]), .CONVERSION_DONE(evt[2]),
    .COMPARATOR_CHANGE(evt[1]), .TIMER1_OVERFLOW(evt[0]),
    .PERIPH_IRQ_REQ(req), .IRQ(irq));
  pir_periph u_per (.clk(clk), .fire(fire), .evt(evt));
  always #25 clk = ~clk;
  // flag bits expected from a set of events
  function [31:0] fmap(input [3:0] f);
    fmap = {24'h0, f[3], f[2], 2'h0, f[1], 2'h0, f[0]};
  endfunction
  task chk(input [31:0] s, input [31:0] x);
    begin
      total_checks = total_checks + 1;
      if (s !== x)
      begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, s, x);
      end
    end
  endtask
  // one apb transfer, waits for pready
  task apb(input w, input [11:0] a, input [31:0] wd);
    begin
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      pa <= a;
      pwd <= wd;
      @(posedge clk);
      pen <= 1'h1;
      @(posedge clk);
      while (rdy !== 1'h1)
        @(posedge clk);
      d = prd;
      e = err;
      psel <= 1'h0;
      pen <= 1'h0;
    end
  endtask
  task pulse(input [3:0] f);
    begin
      fire <= f;
      @(posedge clk);
      fire <= 4'h0;
      repeat (2) @(posedge clk);
    end
  endtask
  task test_done;
    begin
      if (n_fail == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    v = $urandom(90678);
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    apb(0, `PIR_OFS_FLAGS, 0);
    chk(d, 0);
    apb(0, 12'h010, 0);
    chk(e, 1);
    // random writes keep only live bits
    for (i = 0; i < 8; i = i + 1)
    begin
      v = $urandom;
      apb(1, i[0] ? `PIR_OFS_FLAGS : `PIR_OFS_ENABLES, v);
      apb(0, pa, 0);
      chk(d, v & 32'hC9);
    end
    apb(1, `PIR_OFS_FLAGS, 0);
    // random events, flags cleared after
    for (i = 0; i < 8; i = i + 1)
    begin
      v = $urandom;
      pulse(v[3:0]);
      apb(0, `PIR_OFS_FLAGS, 0);
      chk(d, fmap(v[3:0]));
      apb(1, `PIR_OFS_FLAGS, 0);
    end
    // events held across a clearing write
    fire <= 4'hF;
    apb(1, `PIR_OFS_FLAGS, 0);
    pulse(4'h0);
    apb(0, `PIR_OFS_FLAGS, 0);
    chk(d, 32'hC9);
    apb(1, `PIR_OFS_FLAGS, 0);
    apb(1, `PIR_OFS_ENABLES, 1);
    apb(1, `PIR_OFS_IRQ_MASK, 32'h8);
    apb(0, `PIR_OFS_IRQ_STAT, 0);
    @(posedge clk);
    chk(irq, 0);
    pulse(4'h9);
    chk(irq, 1);
    // gate combinations for the request
    for (i = 0; i < 4; i = i + 1)
    begin
      apb(1, `PIR_OFS_CONTROL, i);
      apb(0, `PIR_OFS_CONTROL, 0);
      chk(d, i);
      chk(req, i == 3);
    end
    apb(1, `PIR_OFS_ENABLES, 0);
    @(posedge clk);
    chk(req, 0);
    apb(0, `PIR_OFS_IRQ_STAT, 0);
    chk(d, 32'h9);
    @(posedge clk);
    chk(irq, 0);
    test_done;
  end
  // watchdog
  initial
  begin
    #400000;
    n_fail = n_fail + 1;
    test_done;
  end
endmodule // peripheral_interrupt_regs_test
